// ==== hdl/mvr_ctrl.sv ====
// The APB interface to the registers and the address map were decided locally.
module mvr_ctrl #(
  parameter logic [13:0] DEB_LONG = 14'(mvr_pkg::DEB_LONG_CYC),
  parameter logic [13:0] DEB_SHORT = 14'(mvr_pkg::DEB_SHORT_CYC)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mvr_pkg::mvr_sw_t sw,
  input wire logic debounce_time_select,
  input wire mvr_pkg::mvr_pins_t pins,
  input wire logic mem_rdata,
  output mvr_pkg::mvr_mem_t mem,
  output logic synth_voice_output,
  output logic speech_idle_indication
);
  import mvr_pkg::*;

  typedef struct packed {
    mvr_pins_t s1;
    mvr_pins_t s2;
    logic deb1;
    logic deb2;
    mvr_state_t state;
    logic [23:0] addr;
    logic [23:0] stop;
    logic [23:0] start_addr;
    logic [23:0] maxaddr;
    logic [7:0] trig;
    logic [3:0] phrase;
    logic [1:0] rate;
    logic full;
    logic idle;
    logic [11:0] bit_cnt;
    logic [15:0][47:0] idx;
    logic [31:0] rdata;
    logic we;
    logic re;
    logic wbit;
    logic voice;
  } mvr_ctrl_t;

  mvr_ctrl_t r;
  mvr_ctrl_t next_r;
  mvr_sw_t ev;
  mvr_sw_t deb_ev;
  mvr_pins_t p;
  logic tick;
  logic any_ev;
  logic start_ev;
  logic acc_wr;

  // Cycles per voice bit for each rate code
  function automatic logic [11:0] rate_div(input logic [1:0] code);
    case (code)
      2'b00: rate_div = DIV_11K;
      2'b01: rate_div = DIV_16K;
      2'b10: rate_div = DIV_22K;
      default: rate_div = DIV_32K;
    endcase
  endfunction : rate_div

  // Advance without passing the top of memory
  function automatic logic [23:0] adv(input logic [23:0] a,
                                      input logic [23:0] inc,
                                      input logic [23:0] top);
    if (top - a < inc) begin
      adv = top;
    end else begin
      adv = a + inc;
    end
  endfunction : adv

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == REG_MAXADDR) || (a == REG_TRIG) ||
             (a == REG_STATUS) || (a == REG_ADDR);
  endfunction : mapped

  // Switch debounce; the window also sets the internal start lag
  mvr_debounce #(
    .LONG_CYC(DEB_LONG),
    .SHORT_CYC(DEB_SHORT)
  ) u_deb (
    .pclk(pclk),
    .presetn(presetn),
    .raw(sw),
    .long_sel(r.deb2),
    .rise(deb_ev)
  );

  // Synchronised pins and gated switch events
  always_comb begin
    p = r.s2;
    ev = p.host_mode_select ? mvr_sw_t'(3'h0) : deb_ev;
    any_ev = |ev;
    start_ev = ev.start_primary | ev.start_trigger;
    tick = (r.bit_cnt == rate_div(r.rate) - 12'h001);
    acc_wr = psel & penable & pwrite;
  end

  // One next-state process covers control, counter and registers
  always_comb begin
    next_r = r;
    next_r.s1 = pins;
    next_r.s2 = r.s1;
    next_r.deb1 = debounce_time_select;
    next_r.deb2 = r.deb1;
    next_r.we = 1'b0;
    next_r.re = 1'b0;
    next_r.bit_cnt = tick ? 12'h000 : r.bit_cnt + 12'h001;

    case (r.state)
      S_REC_WAIT: begin
        if (!p.record_select) begin
          next_r.state = S_PLAY_WAIT;
        end else if (start_ev) begin
          next_r.phrase = p.phrase_select_inputs;
          next_r.rate = {p.rate_select_high, p.rate_select_low};
          if (r.full) begin
            next_r.state = S_REC_WAIT;
          end else if (ev.start_primary) begin
            next_r.state = S_REC;
            next_r.start_addr = r.addr;
            next_r.bit_cnt = 12'h000;
            next_r.idx[p.phrase_select_inputs][47:24] = r.addr;
          end else begin
            next_r.state = S_TRIG_WAIT;
          end
        end
        // A pause press here is ignored on purpose
      end
      S_TRIG_WAIT: begin
        if (ev.start_primary) begin
          next_r.addr = adv(r.addr, TRIG_ADV_PRI, r.maxaddr);
          next_r.state = S_REC_WAIT;
        end else if (any_ev) begin
          next_r.addr = adv(r.addr, TRIG_ADV_OTH, r.maxaddr);
          next_r.state = S_REC_WAIT;
        end else if (p.analysis_input > r.trig) begin
          next_r.state = S_REC;
          next_r.start_addr = r.addr;
          next_r.bit_cnt = 12'h000;
          next_r.idx[r.phrase][47:24] = r.addr;
        end
      end
      S_REC: begin
        if (any_ev || r.addr >= r.maxaddr) begin
          next_r.state = S_REC_WAIT;
          next_r.idx[r.phrase] = {r.start_addr, r.addr};
          next_r.full = r.full | (r.addr >= r.maxaddr);
        end else if (tick) begin
          // Strobe and the moved-on address leave together; the bit is for the old one
          next_r.we = 1'b1;
          next_r.wbit = p.voice_bit;
          next_r.addr = r.addr + 24'h000001;
        end
      end
      S_PLAY_WAIT: begin
        if (p.record_select) begin
          next_r.state = S_REC_WAIT;
        end else if (start_ev) begin
          next_r.phrase = p.phrase_select_inputs;
          next_r.rate = {p.rate_select_high, p.rate_select_low};
          next_r.addr = r.idx[p.phrase_select_inputs][47:24];
          next_r.stop = r.idx[p.phrase_select_inputs][23:0];
          next_r.bit_cnt = 12'h000;
          next_r.state = S_PLAY;
        end
      end
      S_PLAY: begin
        if (start_ev || r.addr == r.stop) begin
          next_r.state = S_PLAY_WAIT;
        end else if (ev.pause_stop) begin
          next_r.state = S_PAUSE;
        end else if (tick) begin
          next_r.re = 1'b1;
          next_r.addr = r.addr + 24'h000001;
        end
      end
      S_PAUSE: begin
        if (any_ev) begin
          // Rate may be changed while paused
          next_r.rate = {p.rate_select_high, p.rate_select_low};
          next_r.phrase = p.phrase_select_inputs;
          next_r.state = S_PLAY;
        end
      end
      default: begin
        next_r.state = S_REC_WAIT;
      end
    endcase

    // Read data of the last fetch, muted on request
    if (r.re) begin
      next_r.voice = mem_rdata & ~p.mute_select;
    end else if (p.mute_select || r.state != S_PLAY) begin
      next_r.voice = 1'b0;
    end

    // Clear input restarts the memory and the control flow
    if (!p.clear_input_n) begin
      next_r.addr = 24'h000000;
      next_r.full = 1'b0;
      next_r.we = 1'b0;
      next_r.re = 1'b0;
      next_r.state = p.record_select ? S_REC_WAIT : S_PLAY_WAIT;
    end

    // Idle flag follows the state the same cycle it is entered;
    // lag from the pin is the debounce window plus three clocks
    next_r.idle = (next_r.state == S_REC_WAIT) ||
                  (next_r.state == S_TRIG_WAIT) ||
                  (next_r.state == S_PLAY_WAIT);

    // APB writes take effect at the access edge
    if (acc_wr && paddr == REG_MAXADDR) begin
      next_r.maxaddr = pwdata[23:0];
    end
    if (acc_wr && paddr == REG_TRIG) begin
      next_r.trig = pwdata[7:0];
    end

    // Read data is prepared in the setup cycle, held in access
    if (psel && !penable) begin
      case (paddr)
        REG_MAXADDR: next_r.rdata = {8'h00, r.maxaddr};
        REG_TRIG: next_r.rdata = {24'h000000, r.trig};
        REG_STATUS: begin
          next_r.rdata = 32'h00000000;
          next_r.rdata[ST_STATE_LSB +: 3] = r.state;
          next_r.rdata[ST_FULL] = r.full;
          next_r.rdata[ST_IDLE] = r.idle;
          next_r.rdata[ST_RATE_LSB +: 2] = r.rate;
          next_r.rdata[ST_PHRASE_LSB +: 4] = r.phrase;
        end
        REG_ADDR: next_r.rdata = {8'h00, r.addr};
        default: next_r.rdata = 32'h00000000;
      endcase
    end
  end

  // Reset leaves the block idle in record wait with an empty index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.state <= S_REC_WAIT;
      r.maxaddr <= MAXADDR_RST;
      r.trig <= TRIG_RST;
      r.idle <= 1'b1;
      r.s1.clear_input_n <= 1'b1;
      r.s2.clear_input_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Zero-wait slave; unmapped offsets answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign prdata = r.rdata;
  assign mem.addr = r.addr;
  assign mem.we = r.we;
  assign mem.re = r.re;
  assign mem.wdata = r.wbit;
  assign synth_voice_output = r.voice;
  assign speech_idle_indication = r.idle;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_idle_state;
    r.idle == (r.state inside {S_REC_WAIT, S_TRIG_WAIT, S_PLAY_WAIT});
  endproperty
  a_idle_state: assert property (p_idle_state)
    else $error("idle indication disagrees with state");

  property p_full_refuse;
    r.full && r.state == S_REC_WAIT && p.clear_input_n |=> r.state != S_REC;
  endproperty
  a_full_refuse: assert property (p_full_refuse)
    else $error("recording started with full memory");

  property p_rec_start;
    r.state == S_REC_WAIT && ev.start_primary && !r.full &&
      p.record_select && p.clear_input_n |=> r.state == S_REC;
  endproperty
  a_rec_start: assert property (p_rec_start)
    else $error("primary start did not begin recording");

  property p_rec_stop;
    r.state == S_REC && (any_ev || r.addr >= r.maxaddr)
      |=> r.state == S_REC_WAIT;
  endproperty
  a_rec_stop: assert property (p_rec_stop)
    else $error("recording not stopped");

  property p_pause;
    r.state == S_PLAY && ev == 3'b100 && r.addr != r.stop &&
      p.clear_input_n |=> r.state == S_PAUSE ##1 r.state == S_PAUSE;
  endproperty
  a_pause: assert property (p_pause)
    else $error("pause not entered or not held");

  property p_wait_hold;
    r.state == S_PLAY_WAIT && ev == 3'b100 && !p.record_select &&
      p.clear_input_n |=> $stable(r.state) && $stable(r.addr);
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("pause changed a waiting state");

  property p_trig_skip;
    r.state == S_TRIG_WAIT && ev.start_primary && p.clear_input_n
      |=> r.state == S_REC_WAIT && r.addr - $past(r.addr) <= 24'h000400;
  endproperty
  a_trig_skip: assert property (p_trig_skip)
    else $error("trigger wait skip wrong");

  property p_play_end;
    r.state == S_PLAY && r.addr == r.stop && p.clear_input_n
      |=> r.state == S_PLAY_WAIT;
  endproperty
  a_play_end: assert property (p_play_end)
    else $error("playback passed its stop address");

  property p_rate_hold;
    r.state == S_PLAY && !any_ev |=> $stable(r.rate);
  endproperty
  a_rate_hold: assert property (p_rate_hold)
    else $error("rate changed without a start");

  property p_mute;
    p.mute_select |=> !synth_voice_output;
  endproperty
  a_mute: assert property (p_mute)
    else $error("voice heard while muted");

  property p_clear;
    !p.clear_input_n |=> r.addr == 24'h000000 && !r.full && r.idle;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not restart the block");

  c_record: cover property (r.state == S_REC ##1 r.state == S_REC_WAIT);
  c_trigger: cover property (r.state == S_TRIG_WAIT ##1 r.state == S_REC);
  c_resume: cover property (r.state == S_PAUSE ##1 r.state == S_PLAY);
  c_full: cover property (!r.full ##1 r.full);
endmodule : mvr_ctrl

// ==== hdl/mvr_pkg.sv ====
package mvr_pkg;
  // Address space and register map (APB byte offsets)
  localparam int ADDR_W = 24;
  localparam logic [7:0] REG_MAXADDR = 8'h00;
  localparam logic [7:0] REG_TRIG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_ADDR = 8'h0c;
  localparam logic [23:0] MAXADDR_RST = 24'hffffff;
  localparam logic [7:0] TRIG_RST = 8'h80;
  // Status word field positions
  localparam int ST_STATE_LSB = 0;
  localparam int ST_FULL = 3;
  localparam int ST_IDLE = 4;
  localparam int ST_RATE_LSB = 5;
  localparam int ST_PHRASE_LSB = 7;
  // Switch debounce widths in clock periods
  localparam int DEB_LONG_CYC = 10480;
  localparam int DEB_SHORT_CYC = 400;
  localparam int DEB_W = 14;
  // Bit clock derived from the system clock
  localparam int CLK_HZ = 10_000_000;
  localparam int RATE_11K_HZ = 11_000;
  localparam int RATE_16K_HZ = 16_000;
  localparam int RATE_22K_HZ = 22_000;
  localparam int RATE_32K_HZ = 32_000;
  localparam logic [11:0] DIV_11K = 12'(CLK_HZ / RATE_11K_HZ);
  localparam logic [11:0] DIV_16K = 12'(CLK_HZ / RATE_16K_HZ);
  localparam logic [11:0] DIV_22K = 12'(CLK_HZ / RATE_22K_HZ);
  localparam logic [11:0] DIV_32K = 12'(CLK_HZ / RATE_32K_HZ);
  // Address skip when a trigger wait is abandoned
  localparam logic [23:0] TRIG_ADV_PRI = 24'h000400;
  localparam logic [23:0] TRIG_ADV_OTH = 24'h000001;

  typedef enum logic [2:0] {
    S_REC_WAIT, S_TRIG_WAIT, S_REC, S_PLAY_WAIT, S_PLAY, S_PAUSE
  } mvr_state_t;

  // Debounced switch group: bit 0 primary start, 1 trigger start, 2 pause
  typedef struct packed {
    logic pause_stop;
    logic start_trigger;
    logic start_primary;
  } mvr_sw_t;

  typedef struct packed {
    logic record_select;
    logic rate_select_high;
    logic rate_select_low;
    logic [3:0] phrase_select_inputs;
    logic clear_input_n;
    logic mute_select;
    logic host_mode_select;
    logic voice_bit;
    logic [7:0] analysis_input;
  } mvr_pins_t;

  typedef struct packed {
    logic [23:0] addr;
    logic we;
    logic re;
    logic wdata;
  } mvr_mem_t;
endpackage : mvr_pkg

// ==== hdl/mvr_debounce.sv ====
module mvr_debounce #(
  parameter logic [13:0] LONG_CYC = 14'(mvr_pkg::DEB_LONG_CYC),
  parameter logic [13:0] SHORT_CYC = 14'(mvr_pkg::DEB_SHORT_CYC)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire mvr_pkg::mvr_sw_t raw,
  input wire logic long_sel,
  output mvr_pkg::mvr_sw_t rise
);
  import mvr_pkg::*;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] lvl;
    logic [2:0][13:0] cnt;
    logic [2:0] ev;
  } mvr_deb_t;

  mvr_deb_t r;
  mvr_deb_t next_r;
  logic [13:0] lim;

  // A level is accepted only after it stays put for the whole window
  always_comb begin
    next_r = r;
    lim = long_sel ? SHORT_CYC : LONG_CYC;
    next_r.s1 = raw;
    next_r.s2 = r.s1;
    next_r.ev = 3'h0;
    for (int i = 0; i < 3; i++) begin
      if (r.s2[i] == r.lvl[i]) begin
        next_r.cnt[i] = 14'h0000;
      end else if (r.cnt[i] == lim - 14'h0001) begin
        next_r.lvl[i] = r.s2[i];
        next_r.cnt[i] = 14'h0000;
        next_r.ev[i] = r.s2[i];
      end else begin
        next_r.cnt[i] = r.cnt[i] + 14'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Registered one-cycle pulse per accepted rising level
  assign rise = r.ev;
endmodule : mvr_debounce

// ==== tb/mvr_mem_model.sv ====
module mvr_mem_model
  import mvr_pkg::*;
(
  input wire logic pclk,
  input wire mvr_pkg::mvr_mem_t mem,
  output logic mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  bit store [bit [23:0]];
  logic [23:0] a;

  // Strobe shows the next address, so the bit belongs one address back
  always_comb a = mem.addr - 24'h1;

  // Data line has a pull-up: released, it reads high, never the old bit
  initial mem_rdata = 1'b1;
  always @(posedge pclk) begin
    if (mem.we) begin
      store[a] = mem.wdata;
    end
  end

  // Read answers inside the strobe cycle, where the controller samples it
  always @(mem or a) begin
    if (mem.re) begin
      mem_rdata = store.exists(a) ? store[a] : 1'b1;
    end else begin
      mem_rdata = 1'b1;
    end
  end
endmodule : mvr_mem_model

// ==== tb/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mvr_pkg::*;
  typedef struct packed {
    logic [32:0] v;
    logic [32:0] m;
  } mvr_exp_t;
  localparam logic [32:0] ALL = 33'h1ffffffff;
  localparam int PRI = 0;
  localparam int TRG = 1;
  localparam int PAU = 2;
  localparam logic [11:0] DIVS [4] = '{DIV_11K, DIV_16K, DIV_22K, DIV_32K};
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  mvr_sw_t sw;
  mvr_pins_t pins;
  mvr_mem_t mem;
  logic debounce_time_select, mem_rdata, synth_voice_output;
  logic speech_idle_indication;
  logic [11:0] cnt = 12'h0;
  logic [11:0] gap = 12'h0;
  mvr_exp_t expq [$];
  mvr_exp_t e;
  int mismatches = 0;
  int samples_checked = 0;
  int w;

  always #50 pclk = ~pclk;

  // Short debounce windows keep the run brief
  mvr_ctrl #(.DEB_LONG(14'd20), .DEB_SHORT(14'd8)) mvr_ctrl_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sw(sw),
    .debounce_time_select(debounce_time_select), .pins(pins),
    .mem_rdata(mem_rdata), .mem(mem),
    .synth_voice_output(synth_voice_output),
    .speech_idle_indication(speech_idle_indication)
  );
  mvr_mem_model mvr_mem_model_i (
    .pclk(pclk), .mem(mem), .mem_rdata(mem_rdata)
  );

  task check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [7:0] a, input logic [32:0] v, input logic [32:0] m);
    expq.push_back('{v, m});
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Idle flag is expected high in the three waiting states only
  task st(input logic [2:0] s, input logic f);
    logic i;
    i = (s == 3'd0 || s == 3'd1 || s == 3'd3);
    rd(REG_STATUS, {28'h0, i, f, s}, (s == 3'd5) ? 33'hf : 33'h1f);
  endtask : st

  // Held past the window, then released for as long again
  task press(input int b);
    w = debounce_time_select ? 8 : 20;
    @(posedge pclk);
    sw[b] <= 1'b1;
    repeat (w + 6) @(posedge pclk);
    sw[b] <= 1'b0;
    repeat (w + 6) @(posedge pclk);
  endtask : press

  task pulses(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (!(mem.we || mem.re) && k < 3000);
      if (k >= 3000) mismatches++;
    end
  endtask : pulses

  task idle_wait;
    int k;
    k = 0;
    while (speech_idle_indication !== 1'b1 && k < 30000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 30000) mismatches++;
    repeat (4) @(posedge pclk);
  endtask : idle_wait

  task clr;
    @(posedge pclk) pins.clear_input_n <= 1'b0;
    repeat (4) @(posedge pclk);
    pins.clear_input_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : clr

  // Read results are matched against the oldest note in order
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      e = expq.pop_front();
      check({pslverr, prdata} & e.m, e.v & e.m);
    end
  end

  // Spacing between memory strobes gives the bit period
  always @(posedge pclk) begin
    if (mem.we || mem.re) begin
      gap <= cnt + 12'h1;
      cnt <= 12'h0;
    end else begin
      cnt <= cnt + 12'h1;
    end
  end

  bit rec [bit [23:0]];
  logic vexp = 1'b0;
  logic vpend = 1'b0;

  // Each fetch made while unmuted must come out as it was written to that address
  always @(posedge pclk) begin
    if (mem.we) rec[mem.addr - 24'h1] = mem.wdata;
    if (vpend) check({32'h0, synth_voice_output}, {32'h0, vexp});
    vpend <= mem.re && !pins.mute_select;
    vexp <= rec.exists(mem.addr - 24'h1) ? rec[mem.addr - 24'h1] : 1'b1;
  end

  always @(posedge pclk) pins.voice_bit <= 1'($urandom);

  initial begin
    #6000000;
    mismatches++;
    print_verdict();
  end

  initial begin
    void'($urandom(74));
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pins = '0;
    pins.clear_input_n = 1'b1;
    pins.record_select = 1'b1;
    pins.analysis_input = 8'h10;
    sw = '0;
    debounce_time_select = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(REG_MAXADDR, {9'h0, MAXADDR_RST}, ALL);
    rd(REG_TRIG, {25'h0, TRIG_RST}, ALL);
    rd(REG_ADDR, 33'h0, ALL);
    st(3'd0, 1'b0);
    rd(8'h10, {1'b1, 32'h0}, ALL);
    apb(1'b1, REG_STATUS, 32'hffffffff);
    st(3'd0, 1'b0);
    apb(1'b1, REG_MAXADDR, 32'h800);
    rd(REG_MAXADDR, 33'h800, ALL);
    press(PAU);
    st(3'd0, 1'b0);
    press(TRG);
    st(3'd1, 1'b0);
    press(PRI);
    st(3'd0, 1'b0);
    rd(REG_ADDR, 33'h400, ALL);
    press(TRG);
    press(PAU);
    rd(REG_ADDR, 33'h401, ALL);
    press(TRG);
    pins.analysis_input <= 8'($urandom_range(129, 255));
    repeat (8) @(posedge pclk);
    st(3'd2, 1'b0);
    press(PAU);
    st(3'd0, 1'b0);
    pins.analysis_input <= 8'($urandom_range(0, 128));
    // Every rate code, phrase set before each start
    for (int r = 0; r < 4; r++) begin
      pins.phrase_select_inputs <= 4'(r + 4);
      {pins.rate_select_high, pins.rate_select_low} <= 2'(r);
      press(PRI);
      pins.rate_select_low <= ~pins.rate_select_low;
      pulses(3);
      check({21'h0, gap}, {21'h0, DIVS[r]});
      rd(REG_STATUS, {22'h0, 4'(r + 4), 2'(r), 5'h02}, 33'h7ff);
      pulses(5);
      press(TRG);
      st(3'd0, 1'b0);
    end
    pins.record_select <= 1'b0;
    repeat (8) @(posedge pclk);
    st(3'd3, 1'b0);
    press(PAU);
    st(3'd3, 1'b0);
    // Host mode high: switches must be ignored
    pins.host_mode_select <= 1'b1;
    repeat (4) @(posedge pclk);
    press(PRI);
    st(3'd3, 1'b0);
    pins.host_mode_select <= 1'b0;
    repeat (4) @(posedge pclk);
    pins.phrase_select_inputs <= 4'h4;
    {pins.rate_select_high, pins.rate_select_low} <= 2'h3;
    press(PRI);
    rd(REG_STATUS, {22'h0, 4'h4, 2'h3, 5'h04}, 33'h7ff);
    pulses(3);
    check({21'h0, gap}, {21'h0, DIV_32K});
    press(PAU);
    st(3'd5, 1'b0);
    press(PAU);
    st(3'd4, 1'b0);
    pins.mute_select <= 1'b1;
    pulses(1);
    repeat (3) @(posedge pclk);
    check({32'h0, synth_voice_output}, 33'h0);
    press(TRG);
    st(3'd3, 1'b0);
    pins.mute_select <= 1'b0;
    pins.phrase_select_inputs <= 4'h7;
    press(PRI);
    idle_wait();
    st(3'd3, 1'b0);
    // Fill a tiny memory with the long window, then clear it
    pins.record_select <= 1'b1;
    clr();
    st(3'd0, 1'b0);
    apb(1'b1, REG_MAXADDR, 32'h10);
    debounce_time_select <= 1'b0;
    repeat (4) @(posedge pclk);
    press(PRI);
    idle_wait();
    st(3'd0, 1'b1);
    rd(REG_ADDR, 33'h10, ALL);
    press(PRI);
    st(3'd0, 1'b1);
    clr();
    st(3'd0, 1'b0);
    rd(REG_ADDR, 33'h0, ALL);
    repeat (4) @(posedge pclk);
    print_verdict();
  end
endmodule : tb_top
